// ==== hdl/tec_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tec_consts.vh"
// ********************************************
// Tape extended-operations control
// ********************************************
module tec_ctrl (
    // Clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // Processor instruction port
    input  wire        op_valid,
    input  wire [11:0] op_code,
    input  wire [11:0] acc_in,
    input  wire        mode_tape,
    input  wire        int_on,
    input  wire        sf_tape_trap,
    input  wire        sf_instr_trap,
    // Console
    input  wire        format_switch,
    // Tape processor
    input  wire        tape_done_in,
    input  wire [11:0] csum_in,
    input  wire        word_done,
    input  wire        run_cmd,
    input  wire        dir_cmd,
    // Head pins and diagnostic sources
    input  wire        rw_timing,
    input  wire        rw_data,
    input  wire        diag_timing,
    input  wire        diag_data,
    // Processor answers
    output reg         op_end_q,
    output reg         skip_q,
    output reg  [11:0] acc_out_q,
    output reg         acc_load_q,
    output reg         cpu_stall_q,
    output reg         int_req_q,
    output reg  [11:0] int_save_q,
    output reg  [11:0] int_jump_q,
    output reg         trap_req_q,
    output reg  [11:0] trap_addr_q,
    // Tape processor control
    output reg         tape_start_q,
    output reg  [2:0]  tape_unit_q,
    output reg         done_flag_q,
    output reg         busy_q,
    output wire [2:0]  ext_bank,
    output wire        ext_addr_mode,
    output wire        format_en,
    output wire        maint_mode,
    output reg         ctl_timing_q,
    output reg         ctl_data_q,
    // Transport motion
    output wire [7:0]  unit_run,
    output wire [7:0]  unit_dir
);

    // ********************************************
    // Constants and decode
    // ********************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_EXEC = 3'b010;
    localparam [2:0] ST_TWAIT = 3'b100;
    // Cycle counts, cut to counter width on purpose
    localparam integer CYC_S_N = `TEC_CYC_SHORT;
    localparam integer CYC_D_N = `TEC_CYC_DIAG;
    localparam [6:0] CYC_S = CYC_S_N[6:0];
    localparam [6:0] CYC_D = CYC_D_N[6:0];

    // Tape transfer instruction class
    function is_tape;
        input [11:0] op;
        begin
            is_tape = (op[11:6] == `TEC_OP_TAPE_HI);
        end
    endfunction

    // Opcode match ignoring the I bit
    function op_is;
        input [11:0] op;
        input [11:0] base;
        begin
            op_is = ((op & ~(12'h001 << `TEC_OP_IBIT)) == base);
        end
    endfunction

    reg  [11:0] ext_buf_q;        // Extension buffer
    reg  [2:0]  st_q;             // Sequencer state
    reg  [6:0]  cnt_q;            // Execution countdown
    reg  [11:0] op_q;             // Captured instruction
    reg  [11:0] acc_q;            // Captured accumulator
    reg  [1:0]  fsw_s;            // Format switch synchroniser
    reg  [1:0]  rwt_s;            // Head timing synchroniser
    reg  [1:0]  rwd_s;            // Head data synchroniser
    reg         done_clr;         // Flag clear this cycle
    wire        no_pause;         // Non-blocking mode
    wire        trap_on;          // Both trap functions on

    assign no_pause = ext_buf_q[`TEC_XB_NO_PAUSE];
    assign trap_on = sf_tape_trap & sf_instr_trap;
    assign ext_bank = ext_buf_q[`TEC_XB_BANK_HI:`TEC_XB_BANK_LO];
    assign ext_addr_mode = ext_buf_q[`TEC_XB_EXT_ADDR];
    assign format_en = ext_buf_q[`TEC_XB_FORMAT];
    assign maint_mode = ext_buf_q[`TEC_XB_MAINT];

    // ********************************************
    // Pin synchronisers
    // ********************************************
    // Two stages per pin input
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fsw_s <= 2'b00;
            rwt_s <= 2'b00;
            rwd_s <= 2'b00;
        end
        else
        begin
            fsw_s <= {fsw_s[0], format_switch};
            rwt_s <= {rwt_s[0], rw_timing};
            rwd_s <= {rwd_s[0], rw_data};
        end
    end

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_timing_q <= 1'b0;
            ctl_data_q <= 1'b0;
        end
        else if (maint_mode)
        begin
            ctl_timing_q <= diag_timing;
            ctl_data_q <= diag_data;
        end
        else
        begin
            ctl_timing_q <= rwt_s[1];
            ctl_data_q <= rwd_s[1];
        end
    end

    // ********************************************
    // Instruction sequencer
    // ********************************************
    // Flag clear on tape instruction accept or diagnostic load with clear bit
    always @*
    begin
        done_clr = 1'b0;
        if (st_q == ST_IDLE && op_valid && is_tape(op_code) && !trap_on)
            done_clr = 1'b1;
        if (st_q == ST_EXEC && cnt_q == 7'd1 && op_q == `TEC_OP_DIAG_LOAD
            && acc_q[`TEC_AC_CLEAR])
            done_clr = 1'b1;
    end

    // Main sequencer, results and buffer
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= ST_IDLE;
            cnt_q <= 7'd0;
            op_q <= 12'h000;
            acc_q <= 12'h000;
            ext_buf_q <= `TEC_XB_RESET;
            op_end_q <= 1'b0;
            skip_q <= 1'b0;
            acc_out_q <= 12'h000;
            acc_load_q <= 1'b0;
            cpu_stall_q <= 1'b0;
            trap_req_q <= 1'b0;
            trap_addr_q <= 12'h000;
            tape_start_q <= 1'b0;
            tape_unit_q <= 3'd0;
            busy_q <= 1'b0;
        end
        else
        begin
            // One-cycle answers by default
            op_end_q <= 1'b0;
            skip_q <= 1'b0;
            acc_load_q <= 1'b0;
            trap_req_q <= 1'b0;
            tape_start_q <= 1'b0;
            // Operation finished by the tape processor
            if (tape_done_in)
                busy_q <= 1'b0;
            case (st_q)
                ST_IDLE:
                begin
                    if (op_valid)
                    begin
                        op_q <= op_code;
                        acc_q <= acc_in;
                        cpu_stall_q <= 1'b1;
                        st_q <= ST_EXEC;
                        // Decode time
                        if (op_code == `TEC_OP_DIAG_LOAD)
                            cnt_q <= CYC_D;
                        else
                            cnt_q <= CYC_S;
                    end
                end
                ST_EXEC:
                begin
                    cnt_q <= cnt_q - 7'd1;
                    if (cnt_q == 7'd1)
                    begin
                        st_q <= ST_IDLE;
                        cpu_stall_q <= 1'b0;
                        op_end_q <= 1'b1;
                        if (is_tape(op_q))
                        begin
                            if (trap_on)
                            begin
                                trap_req_q <= 1'b1;
                                trap_addr_q <= `TEC_VEC_TRAP;
                            end
                            else
                            begin
                                tape_unit_q <= {ext_buf_q[`TEC_XB_UNIT_HI],
                                                ext_buf_q[`TEC_XB_UNIT_LO],
                                                op_q[`TEC_OP_UNIT]};
                                tape_start_q <= 1'b1;
                                busy_q <= 1'b1;
                                if (!no_pause)
                                begin
                                    st_q <= ST_TWAIT;
                                    cpu_stall_q <= 1'b1;
                                    op_end_q <= 1'b0;
                                end
                            end
                        end
                        else if (op_q == `TEC_OP_ACC_TO_BUF)
                        begin
                            ext_buf_q <= acc_q;
                            ext_buf_q[`TEC_XB_FORMAT] <= acc_q[`TEC_AC_FORMAT] & fsw_s[1];
                        end
                        else if (op_q == `TEC_OP_BUF_TO_ACC)
                        begin
                            acc_out_q <= ext_buf_q;
                            acc_load_q <= 1'b1;
                        end
                        else if (op_is(op_q, `TEC_OP_SKIP_FIN))
                            skip_q <= op_q[`TEC_OP_IBIT] ? busy_q : ~busy_q;
                        else if (op_is(op_q, `TEC_OP_SKIP_WORD))
                            skip_q <= word_done;
                        else if (op_q == `TEC_OP_DIAG_LOAD)
                            skip_q <= acc_q[`TEC_AC_SKIP] & done_flag_q;
                    end
                end
                ST_TWAIT:
                begin
                    if (tape_done_in)
                    begin
                        st_q <= ST_IDLE;
                        cpu_stall_q <= 1'b0;
                        op_end_q <= 1'b1;
                        acc_out_q <= csum_in;
                        acc_load_q <= 1'b1;
                    end
                end
                default:
                begin
                    st_q <= ST_IDLE;
                    cpu_stall_q <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************
    // Done flag and interrupt
    // ********************************************
    // Set wins over clear
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            done_flag_q <= 1'b0;
        else if (tape_done_in)
            done_flag_q <= 1'b1;
        else if (done_clr)
            done_flag_q <= 1'b0;
    end

    // Interrupt level and vector
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_req_q <= 1'b0;
            int_save_q <= 12'h000;
            int_jump_q <= 12'h000;
        end
        else
        begin
            int_req_q <= ext_buf_q[`TEC_XB_INT_EN] & int_on & done_flag_q;
            int_save_q <= mode_tape ? `TEC_VEC_TSAVE : `TEC_VEC_OSAVE;
            int_jump_q <= mode_tape ? `TEC_VEC_TJUMP : `TEC_VEC_OJUMP;
        end
    end

    // ********************************************
    // Transport motion
    // ********************************************
    tec_motion u_motion (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .sel     (tape_unit_q),
        .hold    (ext_buf_q[`TEC_XB_HOLD]),
        .run_cmd (run_cmd),
        .dir_cmd (dir_cmd),
        .run_q   (unit_run),
        .dir_q   (unit_dir)
    );

endmodule // tec_ctrl
`default_nettype wire

// ==== hdl/tec_motion.v ====
`timescale 1ns/1ps
`default_nettype none
// ********************************************
// Per-transport motion tracking
// ********************************************
module tec_motion (
    // Clock and reset
    input  wire       mclk,
    input  wire       rst_n,
    // Selection and hold
    input  wire [2:0] sel,
    input  wire       hold,
    // Motion of the selected transport
    input  wire       run_cmd,
    input  wire       dir_cmd,
    // Per-transport motion outputs
    output reg  [7:0] run_q,
    output reg  [7:0] dir_q
);

    integer i;

    // Selected unit follows the tape logic; others stop or coast
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_q <= 8'h00;
            dir_q <= 8'h00;
        end
        else
        begin
            for (i = 0; i < 8; i = i + 1)
            begin
                // Selected unit tracks commanded motion
                if (sel == i[2:0])
                begin
                    run_q[i] <= run_cmd;
                    dir_q[i] <= dir_cmd;
                end
                else if (!hold)
                begin
                    run_q[i] <= 1'b0;
                end
            end
        end
    end

endmodule // tec_motion
`default_nettype wire

// ==== include/tec_consts.vh ====
`ifndef TEC_CONSTS_VH
`define TEC_CONSTS_VH

// Extension buffer bit positions (bit 0 is the LSB)
`define TEC_XB_BANK_HI   11
`define TEC_XB_BANK_LO   9
`define TEC_XB_FORMAT    7
`define TEC_XB_INT_EN    6
`define TEC_XB_MAINT     5
`define TEC_XB_EXT_ADDR  4
`define TEC_XB_NO_PAUSE  3
`define TEC_XB_HOLD      2
`define TEC_XB_UNIT_HI   1
`define TEC_XB_UNIT_LO   0
`define TEC_XB_RESET     12'h000

// Accumulator bits used by the diagnostic load and buffer load
`define TEC_AC_SKIP      6
`define TEC_AC_CLEAR     7
`define TEC_AC_FORMAT    7

// Instruction bits
`define TEC_OP_UNIT      3
`define TEC_OP_IBIT      4

// Opcodes
`define TEC_OP_ACC_TO_BUF 12'h001
`define TEC_OP_BUF_TO_ACC 12'h011
`define TEC_OP_SKIP_FIN   12'h10e
`define TEC_OP_SKIP_WORD  12'h10f
`define TEC_OP_DIAG_LOAD  12'hc69
`define TEC_OP_TAPE_HI   6'h07

// Vector addresses
`define TEC_VEC_TSAVE    12'h020
`define TEC_VEC_TJUMP    12'h021
`define TEC_VEC_OSAVE    12'h000
`define TEC_VEC_OJUMP    12'h001
`define TEC_VEC_TRAP     12'h060

// Timing
`define TEC_CLK_NS       100
`define TEC_T_SHORT_NS   1600
`define TEC_T_DIAG_NS    5900
`define TEC_CYC_SHORT    ((`TEC_T_SHORT_NS + `TEC_CLK_NS - 1) / `TEC_CLK_NS)
`define TEC_CYC_DIAG     ((`TEC_T_DIAG_NS + `TEC_CLK_NS - 1) / `TEC_CLK_NS)

`endif

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tec_consts.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
// ****************
// Bench top
// ****************
module tb;
    // Stimulus
    logic        mclk;
    logic        rst_n = 1'b0;
    logic        op_valid = 1'b0;
    logic [11:0] op_code = 12'h000;
    logic [11:0] acc_in = 12'h000;
    logic        mode_tape = 1'b1;
    logic        int_on = 1'b1;
    logic        sf_tape_trap = 1'b0;
    logic        sf_instr_trap = 1'b0;
    logic        format_switch = 1'b0;
    logic        run_cmd = 1'b1;
    logic        dir_cmd = 1'b0;
    logic        diag_timing = 1'b0;
    logic        diag_data = 1'b0;
    logic [7:0]  lag = 8'd80;
    // Answers
    logic tape_done_in, word_done, rw_timing, rw_data, op_end_q, skip_q, acc_load_q;
    logic cpu_stall_q, int_req_q, trap_req_q, tape_start_q, done_flag_q, busy_q;
    logic ext_addr_mode, format_en, maint_mode, ctl_timing_q, ctl_data_q;
    logic [11:0] csum_in, acc_out_q, int_save_q, int_jump_q, trap_addr_q;
    logic [2:0]  tape_unit_q, ext_bank;
    logic [7:0]  unit_run, unit_dir;
    // Bench state
    int          fails = 0;
    int          tests_run = 0;
    int          n;
    logic        sk, ld, tr;
    logic [11:0] ao;
    logic [3:0]  u;
    tec_ctrl dut_u (
        .mclk, .rst_n, .op_valid, .op_code, .acc_in, .mode_tape, .int_on,
        .sf_tape_trap, .sf_instr_trap, .format_switch, .tape_done_in, .csum_in,
        .word_done, .run_cmd, .dir_cmd, .rw_timing, .rw_data, .diag_timing,
        .diag_data, .op_end_q, .skip_q, .acc_out_q, .acc_load_q, .cpu_stall_q,
        .int_req_q, .int_save_q, .int_jump_q, .trap_req_q, .trap_addr_q,
        .tape_start_q, .tape_unit_q, .done_flag_q, .busy_q, .ext_bank,
        .ext_addr_mode, .format_en, .maint_mode, .ctl_timing_q, .ctl_data_q,
        .unit_run, .unit_dir
    );
    tec_tape_model far_u (
        .mclk, .rst_n, .start(tape_start_q), .lag, .done(tape_done_in),
        .csum(csum_in), .word(word_done), .head_timing(rw_timing), .head_data(rw_data)
    );
    // Clock
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Step past edges
    task automatic tick(input int k);
        repeat (k)
        begin
            @(posedge mclk);
            #1;
        end
    endtask
    // Verdict and end
    task automatic wrap_up;
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Hang cut short
    task automatic bail;
        fails++;
        wrap_up();
    endtask
    // Offer one instruction, wait for its end
    task automatic op(input logic [11:0] c, input logic [11:0] a);
        tick(1);
        op_valid = 1'b1;
        op_code = c;
        acc_in = a;
        tick(1);
        op_valid = 1'b0;
        n = 0;
        while (op_end_q !== 1'b1 && n < 400)
        begin
            tick(1);
            n++;
        end
        sk = skip_q;
        ld = acc_load_q;
        tr = trap_req_q;
        ao = acc_out_q;
        if (n >= 400)
            bail();
    endtask
    task automatic wait_done;
        n = 0;
        while (done_flag_q !== 1'b1 && n < 400)
        begin
            tick(1);
            n++;
        end
        if (n >= 400)
            bail();
    endtask
    // Main sequence
    initial
    begin
        tick(10);
        rst_n = 1'b1;
        `CHK("bufout", 6'h00, {ext_bank, ext_addr_mode, format_en, maint_mode})
        op(`TEC_OP_BUF_TO_ACC, 12'h000);
        `CHK("rdbuf0", 13'h1000, {ld, ao})
        op(`TEC_OP_ACC_TO_BUF, 12'he90);
        `CHK("wrtime", 16, n)
        `CHK("bank", 5'h1e, {ext_bank, ext_addr_mode, format_en})
        op(`TEC_OP_BUF_TO_ACC, 12'h000);
        `CHK("rdbuf1", 12'he10, ao)
        format_switch = 1'b1;
        op(`TEC_OP_ACC_TO_BUF, 12'h080);
        `CHK("fmt", 1'b1, format_en)
        format_switch = 1'b0;
        for (u = 4'h0; u < 4'h8; u++)
        begin
            op(`TEC_OP_ACC_TO_BUF, {9'h001, 1'b0, u[2:1]});
            op({8'h1c, u[0], 3'h0}, 12'h000);
            `CHK("nbtime", 16, n)
            `CHK("nbload", 1'b0, ld)
            `CHK("unit", u[2:0], tape_unit_q)
            `CHK("doneclr", 1'b0, done_flag_q)
            op(12'h11e, 12'h000);
            `CHK("finbusy", 1'b1, sk)
            op(`TEC_OP_SKIP_WORD, 12'h000);
            `CHK("wordbusy", 1'b1, sk)
            wait_done();
            op(`TEC_OP_SKIP_FIN, 12'h000);
            `CHK("finidle", 1'b1, sk)
            op(`TEC_OP_SKIP_WORD, 12'h000);
            `CHK("wordidle", 1'b0, sk)
            `CHK("run", 8'h01 << u[2:0], unit_run)
            `CHK("dir", 8'h00, unit_dir)
        end
        dir_cmd = 1'b1;
        op(`TEC_OP_ACC_TO_BUF, 12'h009);
        op(12'h1c0, 12'h000);
        wait_done();
        op(`TEC_OP_ACC_TO_BUF, 12'h00c);
        op(12'h1c0, 12'h000);
        wait_done();
        // Unit 7 keeps the direction it took while still selected
        `CHK("hold", 16'h0585, {unit_run, unit_dir})
        op(`TEC_OP_ACC_TO_BUF, 12'h040);
        op(12'h1c0, 12'h000);
        `CHK("blkwait", 1'b1, n > 16)
        `CHK("blkload", 13'h1fff, {ld, ao})
        tick(2);
        `CHK("irq", 1'b1, int_req_q)
        `CHK("vect", 24'h020021, {int_save_q, int_jump_q})
        mode_tape = 1'b0;
        tick(2);
        `CHK("vec8", 24'h000001, {int_save_q, int_jump_q})
        int_on = 1'b0;
        tick(2);
        `CHK("irqoff", 1'b0, int_req_q)
        int_on = 1'b1;
        tick(2);
        `CHK("irqon", 1'b1, int_req_q)
        op(`TEC_OP_DIAG_LOAD, 12'h040);
        `CHK("diagtime", 59, n)
        `CHK("diagskip", 1'b1, sk)
        op(`TEC_OP_DIAG_LOAD, 12'h0c0);
        `CHK("diagclr", 1'b1, sk)
        tick(2);
        `CHK("irqdrop", 2'b00, {done_flag_q, int_req_q})
        op(`TEC_OP_DIAG_LOAD, 12'h040);
        `CHK("diagnone", 1'b0, sk)
        sf_tape_trap = 1'b1;
        sf_instr_trap = 1'b1;
        op(12'h1c0, 12'h000);
        `CHK("trap", 14'h2060, {tr, busy_q, trap_addr_q})
        sf_tape_trap = 1'b0;
        sf_instr_trap = 1'b0;
        // Head pins reach the control three edges late
        `CHK("heads", {~rw_timing, rw_data ^ rw_timing}, {ctl_timing_q, ctl_data_q})
        op(`TEC_OP_ACC_TO_BUF, 12'h020);
        diag_data = 1'b1;
        tick(3);
        `CHK("maint1", 3'b101, {maint_mode, ctl_timing_q, ctl_data_q})
        diag_timing = 1'b1;
        diag_data = 1'b0;
        tick(3);
        `CHK("maint2", 3'b110, {maint_mode, ctl_timing_q, ctl_data_q})
        wrap_up();
    end
endmodule // tb
`default_nettype wire

// ==== tb/tec_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tec_consts.vh"
// ****************
// Port-level checks
// ****************
module tec_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst_n,
    // Instruction side, tape done and diagnostic data
    input wire logic        op_valid,
    input wire logic [11:0] op_code,
    input wire logic        mode_tape,
    input wire logic        int_on,
    input wire logic        sf_tape_trap,
    input wire logic        sf_instr_trap,
    input wire logic        tape_done_in,
    input wire logic        diag_data,
    // Answers
    input wire logic        op_end_q,
    input wire logic        cpu_stall_q,
    input wire logic        int_req_q,
    input wire logic [11:0] int_save_q,
    input wire logic [11:0] int_jump_q,
    input wire logic        trap_req_q,
    input wire logic [11:0] trap_addr_q,
    input wire logic        tape_start_q,
    input wire logic        done_flag_q,
    input wire logic        format_en,
    input wire logic        maint_mode,
    input wire logic        ctl_data_q
);
    // Accepted instruction and its class
    wire take = op_valid && !cpu_stall_q;
    wire tape = op_code[11:6] == `TEC_OP_TAPE_HI;
    wire trap = sf_tape_trap && sf_instr_trap;
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);
    property p_stall; take |=> cpu_stall_q[*8]; endproperty
    a_stall: assert property (p_stall) else $error("stall not held");
    property p_short;
        take && !tape && op_code != `TEC_OP_DIAG_LOAD |=> !op_end_q[*8] ##9 op_end_q;
    endproperty
    a_short: assert property (p_short) else $error("short op end wrong");
    property p_diag; take && op_code == `TEC_OP_DIAG_LOAD |-> ##60 op_end_q; endproperty
    a_diag: assert property (p_diag) else $error("diag op end wrong");
    property p_done_set; tape_done_in |=> done_flag_q; endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");
    property p_done_clr; take && tape && !trap && !tape_done_in |=> !done_flag_q; endproperty
    a_done_clr: assert property (p_done_clr) else $error("done not cleared");
    property p_int; int_req_q |-> $past(int_on) && $past(done_flag_q); endproperty
    a_int: assert property (p_int) else $error("irq without cause");
    property p_vec;
        $past(rst_n, 2) |-> int_save_q == ($past(mode_tape) ? 12'h020 : 12'h000)
            && int_jump_q == ($past(mode_tape) ? 12'h021 : 12'h001);
    endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_trap;
        take && tape && trap |-> ##17 trap_req_q && op_end_q && !tape_start_q
            && trap_addr_q == 12'h060;
    endproperty
    a_trap: assert property (p_trap) else $error("trap wrong");
    property p_fmt; $rose(format_en) |-> op_end_q; endproperty
    a_fmt: assert property (p_fmt) else $error("format set outside load");
    property p_maint; $past(maint_mode) |-> ctl_data_q == $past(diag_data); endproperty
    a_maint: assert property (p_maint) else $error("diag data not used");
    // Main scenarios reached
    c_start: cover property (tape_start_q);
    c_trap: cover property (trap_req_q);
    c_int: cover property (int_req_q);
endmodule // tec_checker
bind tec_ctrl tec_checker chk_u (
    .mclk, .rst_n, .op_valid, .op_code, .mode_tape, .int_on, .sf_tape_trap,
    .sf_instr_trap, .tape_done_in, .diag_data, .op_end_q, .cpu_stall_q,
    .int_req_q, .int_save_q, .int_jump_q, .trap_req_q, .trap_addr_q,
    .tape_start_q, .done_flag_q, .format_en, .maint_mode, .ctl_data_q
);
`default_nettype wire

// ==== tb/tec_tape_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Tape processor model
// ****************
module tec_tape_model #(
    parameter logic [11:0] CHECK_WORD = 12'hfff  // Transfer check word
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Start and answer delay
    input  wire logic        start,
    input  wire logic [7:0]  lag,
    // Answers
    output var  logic        done,
    output wire logic [11:0] csum,
    output wire logic        word,
    output wire logic        head_timing,
    output wire logic        head_data
);
    logic [7:0] left_q;  // Cycles left
    logic       run_q;   // Operation running
    logic [1:0] free_q;  // Head pattern
    assign csum = done ? CHECK_WORD : ~CHECK_WORD;
    assign word = run_q;
    assign head_timing = free_q[0];
    assign head_data = free_q[1];
    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_q <= 8'h00;
            run_q <= 1'b0;
            done <= 1'b0;
            free_q <= 2'h0;
        end
        else
        begin
            free_q <= free_q + 2'h1;
            done <= run_q && left_q == 8'h00;
            if (start)
            begin
                run_q <= 1'b1;
                left_q <= lag;
            end
            else if (left_q != 8'h00)
                left_q <= left_q - 8'h01;
            else
                run_q <= 1'b0;
        end
    end
endmodule // tec_tape_model
`default_nettype wire
